// File: xms_stretch.sv
// External data memory access engine with stretch, pointers and AHB-Lite
// Overview of operation
// - One instruction cycle lasts 4 system clocks instead of 12.
// - Timers advance every 12 clocks by default, every 4 in fast mode.
// - Two independent data pointers address external data memory.
// - An external move lasts two to nine instruction cycles.
// - Stretch field value plus 2 gives the cycles; it resets to 001.
// - Strobe lasts 2 clocks at 000, otherwise 4 times the field value.
// - A 16-bit address: high byte on port two, low byte muxed on port zero.
// - A configuration bit gives both ports to the bus or to general I/O.
// - Only timing differs from the reference core, never the data effect.
`timescale 1ns/100ps
`default_nettype none
module xms_stretch (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port zero: muxed low address and data
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe,
  // Port two: high address or general I/O
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_oe,
  // Bus strobes: address latch active high, read and write strobes active low
  output logic addr_latch,
  output logic read_strobe_n,
  output logic write_strobe_n
);
  logic [7:0] clock_timing_control;
  logic [5:0] access_ctrl;
  logic [15:0] access_addr;
  logic [7:0] write_data, read_data;
  logic [15:0] data_pointer_reg [2];
  logic [7:0] gpio0_out, gpio0_oe, gpio2_out, gpio2_oe;
  logic [7:0] zero_meta, zero_sync, two_meta, two_sync;
  xms_pkg::xms_state_t state;
  logic [5:0] phase_cnt;
  logic [5:0] strobe_len;
  logic [5:0] tail_len;
  logic busy, done;
  logic cur_write, cur_ptr;
  logic [15:0] cur_addr;
  logic [15:0] timer_count;
  logic dp_wr, dp_rd;
  logic [11:0] dp_addr;
  logic [31:0] next_hrdata;
  logic start;
  logic bus_mode;

  // Strobe width in system clocks for a stretch value
  function automatic logic [5:0] strobe_clks(input logic [2:0] md);
    strobe_clks = (md == 3'h0) ? xms_pkg::STROBE_MIN_CLKS
      : {1'b0, md, 2'b00};
  endfunction

  // Whole move length in clocks: (value + 2) instruction cycles
  function automatic logic [5:0] move_clks(input logic [2:0] md);
    move_clks = 6'({3'h0, md} + 6'h2) * 6'(xms_pkg::CLKS_PER_ICYCLE);
  endfunction

  // Bus mode already holds for the start write that sets it
  assign bus_mode = access_ctrl[xms_pkg::CTRL_BUSEN_BIT] || start;
  assign strobe_len = strobe_clks(clock_timing_control[2:0]);
  assign tail_len = move_clks(clock_timing_control[2:0]) - strobe_len
    - 6'(xms_pkg::ADDR_PHASE_CLKS);
  assign start = dp_wr && dp_addr == xms_pkg::OFF_ACCESS_CTRL
    && hwdata[xms_pkg::CTRL_START_BIT] && !busy
    && hwdata[xms_pkg::CTRL_BUSEN_BIT];
  assign busy = (state != xms_pkg::XMS_IDLE);
  assign done = (state == xms_pkg::XMS_HOLD) && (phase_cnt == 6'h01);

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 12'h000;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite;
      dp_rd <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr;
    end
  end

  // Ready and response are constant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read mux, registered in the address phase for the data phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr)
      xms_pkg::OFF_CLOCK_TIMING_CONTROL: next_hrdata = {24'h0,
        clock_timing_control};
      xms_pkg::OFF_ACCESS_CTRL: next_hrdata = {26'h0, access_ctrl};
      xms_pkg::OFF_ACCESS_ADDR: next_hrdata = {16'h0, access_addr};
      xms_pkg::OFF_ACCESS_DATA: next_hrdata = {16'h0, read_data, write_data};
      xms_pkg::OFF_STATUS: next_hrdata = {15'h0, busy, two_sync, zero_sync};
      xms_pkg::OFF_POINTER0: next_hrdata = {16'h0, data_pointer_reg[0]};
      xms_pkg::OFF_POINTER1: next_hrdata = {16'h0, data_pointer_reg[1]};
      xms_pkg::OFF_TIMER: next_hrdata = {16'h0, timer_count};
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  // Read data is presented in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Clock timing control, stretch field resets to 001
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_timing_control <= xms_pkg::CLOCK_TIMING_CONTROL_RST;
    end else if (dp_wr && dp_addr == xms_pkg::OFF_CLOCK_TIMING_CONTROL) begin
      clock_timing_control <= hwdata[7:0];
    end
  end

  // Access control, address and write data; start bit self clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      access_ctrl <= 6'h00;
      access_addr <= 16'h0000;
      write_data <= 8'h00;
    end else begin
      if (dp_wr && dp_addr == xms_pkg::OFF_ACCESS_CTRL) begin
        access_ctrl <= {hwdata[5:1], 1'b0};
      end
      if (dp_wr && dp_addr == xms_pkg::OFF_ACCESS_ADDR) begin
        access_addr <= hwdata[15:0];
      end
      if (dp_wr && dp_addr == xms_pkg::OFF_ACCESS_DATA) begin
        write_data <= hwdata[7:0];
      end
    end
  end

  // Two independent data pointers with optional increment after a move
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_pointer_reg[0] <= 16'h0000;
      data_pointer_reg[1] <= 16'h0000;
    end else begin
      if (dp_wr && dp_addr == xms_pkg::OFF_POINTER0) begin
        data_pointer_reg[0] <= hwdata[15:0];
      end
      if (dp_wr && dp_addr == xms_pkg::OFF_POINTER1) begin
        data_pointer_reg[1] <= hwdata[15:0];
      end
      if (done && access_ctrl[xms_pkg::CTRL_USEPTR_BIT]
          && access_ctrl[xms_pkg::CTRL_AUTOINC_BIT]) begin
        data_pointer_reg[cur_ptr] <= data_pointer_reg[cur_ptr] + 16'h0001;
      end
    end
  end

  // General I/O drive values, used when bus mode is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {gpio0_out, gpio0_oe, gpio2_out, gpio2_oe} <= 32'h0000_0000;
    end else if (dp_wr && dp_addr == xms_pkg::OFF_STATUS) begin
      {gpio2_oe, gpio2_out, gpio0_oe, gpio0_out} <= hwdata;
    end
  end

  // Two-flop synchronisers on the port inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {zero_meta, zero_sync, two_meta, two_sync} <= 32'h0000_0000;
    end else begin
      zero_meta <= port_zero_in;
      zero_sync <= zero_meta;
      two_meta <= port_two_in;
      two_sync <= two_meta;
    end
  end

  // Move sequencer: address phase, strobe, then hold to fill the cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= xms_pkg::XMS_IDLE;
      phase_cnt <= 6'h00;
      cur_write <= 1'b0;
      cur_ptr <= 1'b0;
      cur_addr <= 16'h0000;
      read_data <= 8'h00;
    end else begin
      unique case (state)
        xms_pkg::XMS_IDLE: if (start) begin
          state <= xms_pkg::XMS_ADDR;
          phase_cnt <= 6'(xms_pkg::ADDR_PHASE_CLKS);
          cur_write <= hwdata[xms_pkg::CTRL_WRITE_BIT];
          cur_ptr <= hwdata[xms_pkg::CTRL_PTRSEL_BIT];
          cur_addr <= hwdata[xms_pkg::CTRL_USEPTR_BIT]
            ? data_pointer_reg[hwdata[xms_pkg::CTRL_PTRSEL_BIT]]
            : access_addr;
        end
        xms_pkg::XMS_ADDR: if (phase_cnt == 6'h01) begin
          state <= xms_pkg::XMS_STRB;
          phase_cnt <= strobe_len;
        end else begin
          phase_cnt <= phase_cnt - 6'h01;
        end
        xms_pkg::XMS_STRB: if (phase_cnt == 6'h01) begin
          state <= xms_pkg::XMS_HOLD;
          phase_cnt <= tail_len;
        end else begin
          phase_cnt <= phase_cnt - 6'h01;
        end
        xms_pkg::XMS_HOLD: if (phase_cnt <= 6'h01) begin
          state <= xms_pkg::XMS_IDLE;
        end else begin
          phase_cnt <= phase_cnt - 6'h01;
          // Synchroniser lag: the last strobe cycle reaches zero_sync now
          if (!cur_write && phase_cnt == tail_len - 6'h01) begin
            read_data <= zero_sync;
          end
        end
      endcase
    end
  end

  // Pin drivers: bus use or general I/O per configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_zero_out <= 8'h00;
      port_zero_oe <= 8'h00;
      port_two_out <= 8'h00;
      port_two_oe <= 8'h00;
      addr_latch <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if (bus_mode) begin
      port_two_out <= busy || start ? (start ? (hwdata[3]
        ? data_pointer_reg[hwdata[2]][15:8] : access_addr[15:8])
        : cur_addr[15:8]) : 8'h00;
      port_two_oe <= 8'hff;
      addr_latch <= start;
      if (start) begin
        port_zero_out <= hwdata[3] ? data_pointer_reg[hwdata[2]][7:0]
          : access_addr[7:0];
        port_zero_oe <= 8'hff;
      end else if (state == xms_pkg::XMS_ADDR && phase_cnt == 6'h01) begin
        port_zero_out <= write_data;
        port_zero_oe <= {8{cur_write}};
        read_strobe_n <= cur_write;
        write_strobe_n <= !cur_write;
      end else if (state == xms_pkg::XMS_STRB && phase_cnt == 6'h01) begin
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
      end else if (done || state == xms_pkg::XMS_IDLE) begin
        port_zero_oe <= 8'h00;
      end
    end else begin
      port_zero_out <= gpio0_out;
      port_zero_oe <= gpio0_oe;
      port_two_out <= gpio2_out;
      port_two_oe <= gpio2_oe;
      addr_latch <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end
  end

  // Timer runs at 12 or 4 clocks per count
  xms_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .fast(clock_timing_control[xms_pkg::TIMER_FAST_BIT]),
    .count(timer_count)
  );
endmodule // xms_stretch
`default_nettype wire

// File: xms_pkg.sv
// Package: register map, field layout, reset values and timing constants
`default_nettype none
package xms_pkg;
  // Register byte addresses (word aligned on AHB-Lite)
  localparam logic [7:0] ADDR_CLOCK_TIMING_CONTROL = 8'h8e; // Not a multiple of 4: index
  localparam logic [11:0] OFF_CLOCK_TIMING_CONTROL = 12'h238; // 4 * 8'h8e
  localparam logic [11:0] OFF_ACCESS_CTRL = 12'h000;
  localparam logic [11:0] OFF_ACCESS_ADDR = 12'h004;
  localparam logic [11:0] OFF_ACCESS_DATA = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_POINTER0 = 12'h010;
  localparam logic [11:0] OFF_POINTER1 = 12'h014;
  localparam logic [11:0] OFF_TIMER = 12'h018;
  // Clock timing control fields
  localparam int STRETCH_LSB = 0;
  localparam int TIMER_FAST_BIT = 3;
  localparam logic [7:0] CLOCK_TIMING_CONTROL_RST = 8'h01;
  // Access control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_PTRSEL_BIT = 2;
  localparam int CTRL_USEPTR_BIT = 3;
  localparam int CTRL_BUSEN_BIT = 4;
  localparam int CTRL_AUTOINC_BIT = 5;
  // Timing counts in system clocks
  localparam logic [3:0] CLKS_PER_ICYCLE = 4'h4;
  localparam logic [3:0] CLKS_PER_TICK_SLOW = 4'hc;
  localparam logic [3:0] CLKS_PER_TICK_FAST = 4'h4;
  localparam logic [5:0] STROBE_MIN_CLKS = 6'h02;
  localparam logic [1:0] ADDR_PHASE_CLKS = 2'h2;
  // Bus access sequencer states
  typedef enum logic [1:0] {
    XMS_IDLE = 2'b00,
    XMS_ADDR = 2'b01,
    XMS_STRB = 2'b11,
    XMS_HOLD = 2'b10
  } xms_state_t;
endpackage
`default_nettype wire

// File: xms_timer.sv
// Timer tick prescaler and 16-bit counter
`timescale 1ns/100ps
`default_nettype none
module xms_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control and count
  input wire logic fast,
  output logic [15:0] count
);
  logic [3:0] prescale;
  logic [3:0] last_step;
  logic tick;

  // Divide by 12 by default or by 4 in fast mode; a prescaler left
  // above the fast limit by a mode switch wraps at once
  assign last_step = (fast ? xms_pkg::CLKS_PER_TICK_FAST
    : xms_pkg::CLKS_PER_TICK_SLOW) - 4'h1;
  assign tick = (prescale >= last_step);

  // Prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= 4'h0;
    end else if (tick) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // Count advances once per tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end
endmodule // xms_timer
`default_nettype wire

// File: xms_props.sv
// Checker for the external move engine pins and register bus
`timescale 1ns/100ps
`default_nettype none
module xms_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Bus pins
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_zero_oe,
  input wire logic [7:0] port_two_out,
  input wire logic [7:0] port_two_oe,
  input wire logic addr_latch,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic pend;
  logic [2:0] md;
  logic [5:0] lowc;
  logic [5:0] wexp;
  logic idle;
  assign idle = read_strobe_n & write_strobe_n;
  assign wexp = (md == 3'h0) ? 6'h02 : {1'b0, md, 2'b00};
  // Shadow of the stretch field and count of strobe-low cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      md <= 3'h1;
      lowc <= 6'h00;
    end else begin
      pend <= hsel && hready && htrans[1] && hwrite &&
        haddr == xms_pkg::OFF_CLOCK_TIMING_CONTROL;
      if (pend) md <= hwdata[2:0];
      lowc <= idle ? 6'h00 : lowc + 6'h01;
    end
  end
  a_strobe_width: assert property ($rose(idle) |-> lowc == wexp)
    else $error("strobe width differs from stretch setting");
  a_addr_phase: assert property (addr_latch |=> idle ##1 !idle)
    else $error("address phase is not two clocks");
  a_latch_lead: assert property ($fell(idle) |-> $past(addr_latch, 2))
    else $error("strobe without address latch two clocks before");
  a_latch_pulse: assert property (addr_latch |=> !addr_latch)
    else $error("address latch longer than one clock");
  a_one_strobe: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes active together");
  a_addr_drive: assert property (addr_latch |->
    port_zero_oe == 8'hff && port_two_oe == 8'hff)
    else $error("address ports not driven in bus mode");
  a_high_hold: assert property (!idle |-> $stable(port_two_out))
    else $error("high address moved during strobe");
  a_read_release: assert property (!read_strobe_n |->
    port_zero_oe == 8'h00)
    else $error("port zero driven during read strobe");
  a_write_drive: assert property (!write_strobe_n |->
    port_zero_oe == 8'hff)
    else $error("port zero not driven during write strobe");
  c_read_move: cover property ($fell(read_strobe_n));
  c_write_move: cover property ($fell(write_strobe_n));
  c_zero_stretch: cover property ($rose(idle) && md == 3'h0);
endmodule // xms_props
bind xms_stretch xms_props u_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .port_zero_out, .port_zero_oe,
  .port_two_out, .port_two_oe, .addr_latch, .read_strobe_n,
  .write_strobe_n);
`default_nettype wire

// File: xms_mem.sv
// External memory on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module xms_mem (
  // Clock
  input wire logic hclk,
  // Device bus pins
  input wire logic [7:0] port_zero_out,
  input wire logic [7:0] port_two_out,
  input wire logic addr_latch,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  // Level this memory puts on port zero
  output logic [7:0] mem_drive
);
  logic [7:0] mem [0:65535];
  logic [15:0] lat;
  logic [7:0] last;
  // Latch the address, store writes, remember the last read byte
  always_ff @(posedge hclk) begin
    if (addr_latch) lat <= {port_two_out, port_zero_out};
    if (!write_strobe_n) mem[lat] <= port_zero_out;
    if (!read_strobe_n) last <= mem[lat];
  end
  // Released line shows the inverse of the last byte, never stale data
  assign mem_drive = !read_strobe_n ? mem[lat] : ~last;
endmodule // xms_mem
`default_nettype wire

// File: tb_top.sv
// Testbench for the external move engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_CK = xms_pkg::OFF_CLOCK_TIMING_CONTROL;
  localparam logic [11:0] A_CTL = xms_pkg::OFF_ACCESS_CTRL;
  localparam logic [11:0] A_AD = xms_pkg::OFF_ACCESS_ADDR;
  localparam logic [11:0] A_DAT = xms_pkg::OFF_ACCESS_DATA;
  localparam logic [11:0] A_ST = xms_pkg::OFF_STATUS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] gp0 = 8'h00;
  logic [7:0] gp2 = 8'h00;
  logic gio = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, addr_latch, read_strobe_n, write_strobe_n;
  logic [7:0] port_zero_in, port_zero_out, port_zero_oe, mem_drive;
  logic [7:0] port_two_out, port_two_oe, hi_seen, lo_seen;
  logic [5:0] lowc;
  int n_fail = 0;
  int checked = 0;
  int polls = 0;
  always #50 hclk = ~hclk;
  xms_stretch dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .port_zero_in, .port_zero_out, .port_zero_oe, .port_two_in(gp2),
    .port_two_out, .port_two_oe, .addr_latch, .read_strobe_n,
    .write_strobe_n);
  xms_mem mem (.hclk, .port_zero_out, .port_two_out, .addr_latch,
    .read_strobe_n, .write_strobe_n, .mem_drive);
  // Pin level from the device, the memory or the general I/O driver
  assign port_zero_in = (port_zero_oe & port_zero_out) |
    (~port_zero_oe & (gio ? gp0 : mem_drive));
  // Strobe width and address seen on the pins
  always @(posedge hclk) begin
    if (addr_latch) lowc <= 6'h00;
    else if (!read_strobe_n || !write_strobe_n) lowc <= lowc + 6'h01;
    if (!read_strobe_n || !write_strobe_n) hi_seen <= port_two_out;
    if (addr_latch) lo_seen <= port_zero_out;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdy();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_fail++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask
  task automatic move(input logic [31:0] ctl);
    logic [31:0] s;
    int i;
    wr(A_CTL, ctl);
    i = 0;
    do begin
      rd(A_ST, s);
      i++;
      if (i > 60) begin
        n_fail++;
        end_sim();
      end
    end while (s[16] !== 1'b0);
    polls = i;
  endtask
  task automatic t_regs();
    logic [31:0] q;
    rd(A_CK, q);
    chk("timing ctrl reset", q, 32'h01);
    chk("ready okay", {30'h0, hreadyout, hresp}, 32'h2);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, q);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_stretch();
    logic [31:0] q;
    logic [15:0] a;
    logic [5:0] w;
    for (int m = 0; m < 8; m++) begin
      a = {5'h18, m[2:0], 5'h05, m[2:0]};
      w = (m == 0) ? 6'h02 : 6'(4 * m);
      wr(A_CK, 32'(m));
      wr(A_AD, {16'h0, a});
      wr(A_DAT, {24'h0, 8'h50 | 8'(m)});
      move(32'h13);
      // m+2 cycles of 4 clocks, polled every 2 clocks, plus the idle poll
      chk("write polls", polls, 32'((m + 2) * 2 + 1));
      chk("write width", lowc, w);
      chk("high addr", hi_seen, a[15:8]);
      chk("low addr", lo_seen, a[7:0]);
      move(32'h11);
      chk("read polls", polls, 32'((m + 2) * 2 + 1));
      chk("read width", lowc, w);
      rd(A_DAT, q);
      chk("read byte", q[15:8], 8'h50 | 8'(m));
    end
    $display("t_stretch done");
  endtask
  task automatic t_ptr();
    logic [31:0] q;
    wr(12'h010, 32'h2001);
    wr(12'h014, 32'h3002);
    wr(A_DAT, 32'ha7);
    move(32'h1b);
    chk("ptr0 high", hi_seen, 8'h20);
    wr(A_DAT, 32'h5e);
    move(32'h3f);
    chk("ptr1 low", lo_seen, 8'h02);
    rd(12'h014, q);
    chk("ptr1 inc", q[15:0], 16'h3003);
    rd(12'h010, q);
    chk("ptr0 kept", q[15:0], 16'h2001);
    move(32'h19);
    rd(A_DAT, q);
    chk("ptr0 read", q[15:8], 8'ha7);
    $display("t_ptr done");
  endtask
  task automatic t_gpio();
    logic [31:0] q;
    wr(A_CTL, 32'h0);
    wr(A_ST, 32'h0f3cff5a);
    repeat (2) @(posedge hclk);
    chk("port zero out", {port_zero_oe, port_zero_out}, 16'hff5a);
    chk("port two out", {port_two_oe, port_two_out}, 16'h0f3c);
    wr(A_ST, 32'h0);
    gio <= 1'b1;
    gp0 <= 8'h96;
    gp2 <= 8'h69;
    repeat (3) @(posedge hclk);
    rd(A_ST, q);
    chk("pins in", q[15:0], 16'h6996);
    $display("t_gpio done");
  endtask
  task automatic t_timer(input logic [7:0] ck, input logic [15:0] d);
    logic [31:0] q1, q2;
    wr(A_CK, {24'h0, ck});
    rd(12'h018, q1);
    repeat (118) @(posedge hclk);
    rd(12'h018, q2);
    chk("timer step", q2[15:0] - q1[15:0], d);
    $display("t_timer done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_stretch();
    t_ptr();
    t_gpio();
    t_timer(8'h01, 16'd10);
    t_timer(8'h09, 16'd30);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
